/* File: logic/dcc_top.sv */
/*
 * Dual comparator control: special function register front end for two
 * identical comparator channels, with analog control outputs.
 * Assumes single-cycle SFR write and read strobes on clk_sys, and the
 * analog comparators, multiplexers and crossbar outside this block.
 */
// Notes on behaviour
// - Two identical channels sharing one control design.
// - Each channel gives a clocked latched output and a raw unclocked output.
// - A disabled channel drives its pin-bound outputs low.
// - Falling transition sets the fall flag; rising transition sets the rise flag.
// - Edge flags stay set until software writes zero; rise bit 5, fall bit 4.
// - Control bit 6 is read-only and shows the current comparator result.
// - Control bit 7 enables the channel; resets to disabled.
// - Control bits 3:2 hold the positive hysteresis code for the comparator.
// - Control bits 1:0 hold the negative hysteresis code for the comparator.
// - Mode bits 1:0 choose response mode; reset value is binary 10.
// - Mode bits 5 and 4 enable rise and fall interrupt requests.
// - Mode bits 7:6 and 3:2 read zero and ignore writes.
// - A per-channel register holds separate positive and negative input selects.
// - Second channel control at 0x9d and mode at 0x9e on page 0x00.
`timescale 1ns/1ps

module dcc_top
    import dcc_pkg::*;
#(
    parameter int unsigned NUM_CH = DCC_NUM_CH
) (
    input  wire logic                  clk_sys,
    input  wire logic                  nrst,
    input  wire logic [DCC_SFR_AW-1:0] sfr_addr,
    input  wire logic [7:0]            sfr_page,
    input  wire logic                  sfr_wr,
    input  wire logic                  sfr_rd,
    input  wire logic [DCC_SFR_DW-1:0] sfr_wdata,
    output logic      [DCC_SFR_DW-1:0] sfr_rdata,
    input  wire logic [NUM_CH-1:0]     cmp_raw_in,
    output logic      [NUM_CH-1:0]     raw_out,
    output logic      [NUM_CH-1:0]     latched_out,
    output logic      [NUM_CH-1:0]     cmp_irq,
    output logic      [NUM_CH-1:0]     cmp_enable,
    output logic      [2*NUM_CH-1:0]   pos_hyst_sel,
    output logic      [2*NUM_CH-1:0]   neg_hyst_sel,
    output logic      [2*NUM_CH-1:0]   response_mode_sel,
    output logic      [4*NUM_CH-1:0]   pos_input_sel,
    output logic      [4*NUM_CH-1:0]   neg_input_sel
);

    if (NUM_CH != DCC_NUM_CH) begin : g_bad_num_ch
        $error("dcc_top serves exactly two comparator channels");
    end

    logic [7:0] mux_reg [NUM_CH];
    logic [7:0] rdata_reg;

    function automatic logic page_hit(input logic [7:0] page,
                                      input logic [7:0] addr,
                                      input logic [7:0] target);
        page_hit = (page == DCC_PAGE_MAIN) && (addr == target);
    endfunction : page_hit

    function automatic logic [7:0] ctrl_addr(input int unsigned idx);
        ctrl_addr = (idx == 0) ? DCC_ADDR_CTRL0 : DCC_ADDR_CTRL1;
    endfunction : ctrl_addr

    function automatic logic [7:0] mode_addr(input int unsigned idx);
        mode_addr = (idx == 0) ? DCC_ADDR_MODE0 : DCC_ADDR_MODE1;
    endfunction : mode_addr

    function automatic logic [7:0] mux_addr(input int unsigned idx);
        mux_addr = (idx == 0) ? DCC_ADDR_MUX0 : DCC_ADDR_MUX1;
    endfunction : mux_addr

    dcc_chan_if chif [NUM_CH] ();
    logic [7:0] ctrl_rd [NUM_CH];
    logic [7:0] mode_rd [NUM_CH];

    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
        // Both channels share one control design
        assign chif[i].wr_ctrl = sfr_wr && page_hit(sfr_page, sfr_addr, ctrl_addr(i));
        assign chif[i].wr_mode = sfr_wr && page_hit(sfr_page, sfr_addr, mode_addr(i));
        assign chif[i].wdata   = sfr_wdata;
        assign chif[i].raw_in  = cmp_raw_in[i];
        assign ctrl_rd[i]      = chif[i].ctrl_val;
        assign mode_rd[i]      = chif[i].mode_val;

        dcc_channel u_chan (
            .clk_sys (clk_sys),
            .nrst    (nrst),
            .ch      (chif[i])
        );

        // Input select register
        always_ff @(posedge clk_sys or negedge nrst) begin
            if (!nrst) begin
                mux_reg[i] <= DCC_MUX_RESET;
            end else if (sfr_wr && page_hit(sfr_page, sfr_addr, mux_addr(i))) begin
                mux_reg[i] <= sfr_wdata;
            end
        end

        // Unclocked path so the raw output works with the clock stopped
        assign raw_out[i] = cmp_raw_in[i] & ctrl_rd[i][DCC_CTRL_EN];

        assign latched_out[i]           = chif[i].latched;
        assign cmp_irq[i]               = chif[i].irq;
        assign cmp_enable[i]            = ctrl_rd[i][DCC_CTRL_EN];
        assign pos_hyst_sel[2*i +: 2]   = ctrl_rd[i][DCC_CTRL_HYP_HI:DCC_CTRL_HYP_LO];
        assign neg_hyst_sel[2*i +: 2]   = ctrl_rd[i][DCC_CTRL_HYN_HI:DCC_CTRL_HYN_LO];
        assign response_mode_sel[2*i +: 2] = mode_rd[i][DCC_MODE_MD_HI:DCC_MODE_MD_LO];
        assign pos_input_sel[4*i +: 4]  = mux_reg[i][DCC_MUX_POS_HI:DCC_MUX_POS_LO];
        assign neg_input_sel[4*i +: 4]  = mux_reg[i][DCC_MUX_NEG_HI:DCC_MUX_NEG_LO];
    end

    // Registered read data; unmapped addresses return zero
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rdata_reg <= 8'h00;
        end else if (sfr_rd) begin
            rdata_reg <= 8'h00;
            for (int i = 0; i < NUM_CH; i++) begin
                if (page_hit(sfr_page, sfr_addr, ctrl_addr(i))) begin
                    rdata_reg <= ctrl_rd[i];
                end
                if (page_hit(sfr_page, sfr_addr, mode_addr(i))) begin
                    rdata_reg <= mode_rd[i];
                end
                if (page_hit(sfr_page, sfr_addr, mux_addr(i))) begin
                    rdata_reg <= mux_reg[i];
                end
            end
        end
    end

    assign sfr_rdata = rdata_reg;

endmodule : dcc_top

/* File: common/dcc_pkg.sv */
/*
 * Constants for the dual comparator control block: special function
 * register addresses, field positions, reset values and masks.
 * Assumes an 8-bit special function register bus with byte addresses.
 */
package dcc_pkg;

    localparam int unsigned DCC_NUM_CH      = 2;
    localparam int unsigned DCC_SFR_AW      = 8;
    localparam int unsigned DCC_SFR_DW      = 8;

    // Special function register addresses, page 0x00
    localparam logic [7:0] DCC_PAGE_MAIN    = 8'h00;
    localparam logic [7:0] DCC_ADDR_CTRL0   = 8'h9a;
    localparam logic [7:0] DCC_ADDR_MODE0   = 8'h9b;
    localparam logic [7:0] DCC_ADDR_MUX0    = 8'h9c;
    localparam logic [7:0] DCC_ADDR_CTRL1   = 8'h9d;
    localparam logic [7:0] DCC_ADDR_MODE1   = 8'h9e;
    localparam logic [7:0] DCC_ADDR_MUX1    = 8'h9f;

    // Control register fields
    localparam int unsigned DCC_CTRL_EN     = 7;
    localparam int unsigned DCC_CTRL_RES    = 6;
    localparam int unsigned DCC_CTRL_RISE   = 5;
    localparam int unsigned DCC_CTRL_FALL   = 4;
    localparam int unsigned DCC_CTRL_HYP_HI = 3;
    localparam int unsigned DCC_CTRL_HYP_LO = 2;
    localparam int unsigned DCC_CTRL_HYN_HI = 1;
    localparam int unsigned DCC_CTRL_HYN_LO = 0;

    // Mode register fields
    localparam int unsigned DCC_MODE_RIE    = 5;
    localparam int unsigned DCC_MODE_FIE    = 4;
    localparam int unsigned DCC_MODE_MD_HI  = 1;
    localparam int unsigned DCC_MODE_MD_LO  = 0;

    // Input select register fields
    localparam int unsigned DCC_MUX_NEG_HI  = 7;
    localparam int unsigned DCC_MUX_NEG_LO  = 4;
    localparam int unsigned DCC_MUX_POS_HI  = 3;
    localparam int unsigned DCC_MUX_POS_LO  = 0;

    // Reset values and writable masks
    localparam logic [7:0] DCC_CTRL_RESET   = 8'h00;
    localparam logic [7:0] DCC_MODE_RESET   = 8'h02;
    localparam logic [7:0] DCC_MODE_MASK    = 8'h33;
    localparam logic [7:0] DCC_MUX_RESET    = 8'h77;

endpackage : dcc_pkg

/* File: common/dcc_chan_if.sv */
/*
 * Carrier between the register front end and one comparator channel.
 * Assumes both ends run on the same system clock.
 */
`timescale 1ns/1ps

interface dcc_chan_if;
    logic       wr_ctrl;
    logic       wr_mode;
    logic [7:0] wdata;
    logic       raw_in;
    logic [7:0] ctrl_val;
    logic [7:0] mode_val;
    logic       latched;
    logic       irq;

    modport front (
        output wr_ctrl,
        output wr_mode,
        output wdata,
        output raw_in,
        input  ctrl_val,
        input  mode_val,
        input  latched,
        input  irq
    );

    modport chan (
        input  wr_ctrl,
        input  wr_mode,
        input  wdata,
        input  raw_in,
        output ctrl_val,
        output mode_val,
        output latched,
        output irq
    );
endinterface : dcc_chan_if

/* File: logic/dcc_channel.sv */
/*
 * One comparator channel: control and mode registers, synchroniser,
 * edge flags and interrupt request.
 * Assumes the raw comparator result is asynchronous to clk_sys.
 */
`timescale 1ns/1ps

module dcc_channel
    import dcc_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic nrst,
    dcc_chan_if.chan  ch
);

    logic       en_reg;
    logic       rise_flag_reg;
    logic       fall_flag_reg;
    logic [1:0] pos_hyst_reg;
    logic [1:0] neg_hyst_reg;
    logic       rise_irq_en_reg;
    logic       fall_irq_en_reg;
    logic [1:0] mode_reg;
    logic       sync1_reg;
    logic       sync2_reg;
    logic       latched_reg;
    logic       irq_reg;
    logic       rise_evt;
    logic       fall_evt;
    logic       rise_flag_next;
    logic       fall_flag_next;
    logic       rise_irq_en_next;
    logic       fall_irq_en_next;

    // Two-stage synchroniser; first stage feeds only the second
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
        end else begin
            sync1_reg <= ch.raw_in;
            sync2_reg <= sync1_reg;
        end
    end

    // Latched output, low while disabled
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            latched_reg <= 1'b0;
        end else begin
            latched_reg <= en_reg & sync2_reg;
        end
    end

    assign rise_evt = en_reg & ~latched_reg & sync2_reg;
    assign fall_evt = en_reg & latched_reg & ~sync2_reg;

    // Hardware set wins over a software write of zero
    assign rise_flag_next = rise_evt | (ch.wr_ctrl ? ch.wdata[DCC_CTRL_RISE] : rise_flag_reg);
    assign fall_flag_next = fall_evt | (ch.wr_ctrl ? ch.wdata[DCC_CTRL_FALL] : fall_flag_reg);

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rise_flag_reg <= DCC_CTRL_RESET[DCC_CTRL_RISE];
            fall_flag_reg <= DCC_CTRL_RESET[DCC_CTRL_FALL];
        end else begin
            rise_flag_reg <= rise_flag_next;
            fall_flag_reg <= fall_flag_next;
        end
    end

    // Control register writable fields
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            en_reg       <= DCC_CTRL_RESET[DCC_CTRL_EN];
            pos_hyst_reg <= DCC_CTRL_RESET[DCC_CTRL_HYP_HI:DCC_CTRL_HYP_LO];
            neg_hyst_reg <= DCC_CTRL_RESET[DCC_CTRL_HYN_HI:DCC_CTRL_HYN_LO];
        end else if (ch.wr_ctrl) begin
            en_reg       <= ch.wdata[DCC_CTRL_EN];
            pos_hyst_reg <= ch.wdata[DCC_CTRL_HYP_HI:DCC_CTRL_HYP_LO];
            neg_hyst_reg <= ch.wdata[DCC_CTRL_HYN_HI:DCC_CTRL_HYN_LO];
        end
    end

    // Mode register; unused bits are never stored
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rise_irq_en_reg <= DCC_MODE_RESET[DCC_MODE_RIE];
            fall_irq_en_reg <= DCC_MODE_RESET[DCC_MODE_FIE];
            mode_reg        <= DCC_MODE_RESET[DCC_MODE_MD_HI:DCC_MODE_MD_LO];
        end else if (ch.wr_mode) begin
            rise_irq_en_reg <= ch.wdata[DCC_MODE_RIE];
            fall_irq_en_reg <= ch.wdata[DCC_MODE_FIE];
            mode_reg        <= ch.wdata[DCC_MODE_MD_HI:DCC_MODE_MD_LO];
        end
    end

    assign rise_irq_en_next = ch.wr_mode ? ch.wdata[DCC_MODE_RIE] : rise_irq_en_reg;
    assign fall_irq_en_next = ch.wr_mode ? ch.wdata[DCC_MODE_FIE] : fall_irq_en_reg;

    // Request tracks flags and enables on the edge they change
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= (rise_flag_next & rise_irq_en_next)
                     | (fall_flag_next & fall_irq_en_next);
        end
    end

    assign ch.ctrl_val = {en_reg, sync2_reg, rise_flag_reg, fall_flag_reg,
                          pos_hyst_reg, neg_hyst_reg};
    assign ch.mode_val = {2'b00, rise_irq_en_reg, fall_irq_en_reg,
                          2'b00, mode_reg} & DCC_MODE_MASK;
    assign ch.latched  = latched_reg;
    assign ch.irq      = irq_reg;

endmodule : dcc_channel

/* File: tb/dcc_top_assertions.sv */
/* Concurrent checks on the dcc_top ports, attached by bind.
   Assumes one clock clk_sys and asynchronous active-low nrst. */
`timescale 1ns/1ps
module dcc_top_chk
    import dcc_pkg::*;
#(
    parameter int unsigned NUM_CH = 2
) (
    input wire logic                clk_sys,
    input wire logic                nrst,
    input wire logic [7:0]          sfr_addr,
    input wire logic [7:0]          sfr_page,
    input wire logic                sfr_wr,
    input wire logic                sfr_rd,
    input wire logic [7:0]          sfr_wdata,
    input wire logic [7:0]          sfr_rdata,
    input wire logic [NUM_CH-1:0]   cmp_raw_in,
    input wire logic [NUM_CH-1:0]   raw_out,
    input wire logic [NUM_CH-1:0]   latched_out,
    input wire logic [NUM_CH-1:0]   cmp_irq,
    input wire logic [NUM_CH-1:0]   cmp_enable,
    input wire logic [2*NUM_CH-1:0] pos_hyst_sel,
    input wire logic [2*NUM_CH-1:0] neg_hyst_sel,
    input wire logic [2*NUM_CH-1:0] response_mode_sel
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    logic w0;
    assign w0 = sfr_wr && sfr_page == DCC_PAGE_MAIN;
    property p_raw_gate; raw_out == (cmp_raw_in & cmp_enable); endproperty
    property p_off_low; !cmp_enable[0] && !$past(cmp_enable[0]) |-> !latched_out[0]; endproperty
    property p_sync;
        cmp_enable[0] && $past(cmp_enable[0]) && $past(cmp_enable[0], 2) && $past(nrst, 3)
            |-> latched_out[0] == $past(cmp_raw_in[0], 3);
    endproperty
    property p_fall; $fell(cmp_irq[0]) |-> $past(sfr_wr); endproperty
    property p_rise; $rose(cmp_irq[0]) |-> $past(sfr_wr) || $changed(latched_out[0]); endproperty
    property p_ctrl0;
        w0 && sfr_addr == DCC_ADDR_CTRL0 |=> cmp_enable[0] == $past(sfr_wdata[7])
            && pos_hyst_sel[1:0] == $past(sfr_wdata[3:2]) && neg_hyst_sel[1:0] == $past(sfr_wdata[1:0]);
    endproperty
    property p_ctrl1;
        w0 && sfr_addr == DCC_ADDR_CTRL1 |=> cmp_enable[1] == $past(sfr_wdata[7])
            && pos_hyst_sel[3:2] == $past(sfr_wdata[3:2])
            && neg_hyst_sel[3:2] == $past(sfr_wdata[1:0]);
    endproperty
    property p_mode; w0 && sfr_addr == DCC_ADDR_MODE0 |=> response_mode_sel[1:0] == $past(sfr_wdata[1:0]); endproperty
    property p_rd_off; sfr_rd && sfr_page != DCC_PAGE_MAIN |=> sfr_rdata == 8'h00; endproperty
    a_raw_gate: assert property (p_raw_gate) else $error("raw output not gated");
    a_off_low: assert property (p_off_low) else $error("latched high while off");
    a_sync: assert property (p_sync) else $error("latched path delay wrong");
    a_fall: assert property (p_fall) else $error("irq dropped without write");
    a_rise: assert property (p_rise) else $error("irq rose without cause");
    a_ctrl0: assert property (p_ctrl0) else $error("control 0 fields wrong");
    a_ctrl1: assert property (p_ctrl1) else $error("control 1 fields wrong");
    a_mode: assert property (p_mode) else $error("response mode wrong");
    a_rd_off: assert property (p_rd_off) else $error("foreign page read nonzero");
    c_irq: cover property ($rose(cmp_irq[0]));
    c_lat1: cover property ($rose(latched_out[1]));
    c_off: cover property (sfr_rd && sfr_page != DCC_PAGE_MAIN);
endmodule : dcc_top_chk

bind dcc_top dcc_top_chk #(.NUM_CH(NUM_CH)) i_chk (
    .clk_sys(clk_sys), .nrst(nrst), .sfr_addr(sfr_addr), .sfr_page(sfr_page),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .cmp_raw_in(cmp_raw_in), .raw_out(raw_out), .latched_out(latched_out), .cmp_irq(cmp_irq),
    .cmp_enable(cmp_enable), .pos_hyst_sel(pos_hyst_sel), .neg_hyst_sel(neg_hyst_sel),
    .response_mode_sel(response_mode_sel));

/* File: tb/dual_comparator_control_tb_top.sv */
/* Self-checking bench for dcc_top over its register strobes.
   Assumes the checker file is compiled alongside. */
`timescale 1ns/1ps
module dual_comparator_control_tb_top;
    import dcc_pkg::*;
    logic       clk_sys = 1'b0;
    logic       nrst = 1'b0;
    logic [7:0] sfr_addr = 8'h00, sfr_page = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
    logic       sfr_wr = 1'b0, sfr_rd = 1'b0;
    logic [1:0] cmp_raw_in = 2'b11, raw_out, latched_out, cmp_irq, cmp_enable;
    logic [3:0] pos_hyst_sel, neg_hyst_sel, response_mode_sel;
    logic [7:0] pos_input_sel, neg_input_sel;
    int         err_total = 0;
    int         checked = 0;
    always #12.5 clk_sys = ~clk_sys;
    dcc_top #(.NUM_CH(2)) i_dut (.clk_sys(clk_sys), .nrst(nrst), .sfr_addr(sfr_addr),
        .sfr_page(sfr_page), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
        .sfr_rdata(sfr_rdata), .cmp_raw_in(cmp_raw_in), .raw_out(raw_out),
        .latched_out(latched_out), .cmp_irq(cmp_irq), .cmp_enable(cmp_enable),
        .pos_hyst_sel(pos_hyst_sel), .neg_hyst_sel(neg_hyst_sel),
        .response_mode_sel(response_mode_sel), .pos_input_sel(pos_input_sel),
        .neg_input_sel(neg_input_sel));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [7:0] pg = 8'h00);
        @(negedge clk_sys);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_page = pg;
        sfr_wr = 1'b1;
        @(negedge clk_sys);
        sfr_wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] pg = 8'h00);
        @(negedge clk_sys);
        sfr_addr = a;
        sfr_page = pg;
        sfr_rd = 1'b1;
        @(negedge clk_sys);
        sfr_rd = 1'b0;
        chk(sfr_rdata, exp);
    endtask : rd
    task automatic complete_run;
        $display("Counts: compares=%0d mismatches=%0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : complete_run
    task automatic edges(input int ch);
        logic [7:0] c;
        logic [7:0] m;
        c = ch ? DCC_ADDR_CTRL1 : DCC_ADDR_CTRL0;
        m = 8'h01 << ch;
        wr(c + 8'h01, 8'h32);
        wr(c, 8'h80);
        repeat (4) @(negedge clk_sys);
        rd(c, 8'h80);
        cmp_raw_in[ch] = 1'b1;
        #1 chk({6'h0, raw_out}, m);
        repeat (4) @(negedge clk_sys);
        chk({6'h0, latched_out}, m);
        chk({6'h0, cmp_irq}, m);
        rd(c, 8'he0);
        cmp_raw_in[ch] = 1'b0;
        repeat (4) @(negedge clk_sys);
        rd(c, 8'hb0);
        repeat (10) @(negedge clk_sys);
        rd(c, 8'hb0);
        wr(c, 8'h90);
        chk({6'h0, cmp_irq}, m);
        wr(c + 8'h01, 8'h22);
        chk({6'h0, cmp_irq}, 8'h00);
        wr(c + 8'h01, 8'h12);
        chk({6'h0, cmp_irq}, m);
        wr(c, 8'h00);
        chk({6'h0, cmp_irq}, 8'h00);
        cmp_raw_in[ch] = 1'b1;
        repeat (4) @(negedge clk_sys);
        chk({4'h0, latched_out, raw_out}, 8'h00);
        rd(c, 8'h40);
        wr(c, 8'h80);
        repeat (4) @(negedge clk_sys);
        rd(c, 8'he0);
        wr(c, 8'h80);
        rd(c, 8'hc0);
        wr(c, 8'h00);
        cmp_raw_in[ch] = 1'b0;
        repeat (4) @(negedge clk_sys);
        $display("edge test done, channel %0d", ch);
    endtask : edges
    initial begin
        #(25 * 4000);
        err_total++;
        complete_run();
    end
    initial begin
        repeat (3) @(negedge clk_sys);
        nrst = 1'b1;
        chk({raw_out, latched_out, response_mode_sel}, 8'h0a);
        chk(pos_input_sel, 8'h77);
        chk(neg_input_sel, 8'h77);
        cmp_raw_in = 2'b00;
        for (int i = 0; i < 2; i++) begin
            rd(DCC_ADDR_CTRL0 + 8'(3 * i), 8'h00);
            rd(DCC_ADDR_MODE0 + 8'(3 * i), 8'h02);
            rd(DCC_ADDR_MUX0 + 8'(3 * i), 8'h77);
        end
        for (logic [2:0] j = 0; j < 4; j++) begin
            wr(DCC_ADDR_CTRL0, {4'h0, j[1:0], ~j[1:0]});
            wr(DCC_ADDR_CTRL1, {4'h0, j[1:0], ~j[1:0]});
            chk({pos_hyst_sel, neg_hyst_sel}, {j[1:0], j[1:0], ~j[1:0], ~j[1:0]});
            wr(DCC_ADDR_MODE0, 8'hcc | 8'(j));
            wr(DCC_ADDR_MODE1, 8'hcc | 8'(j));
            rd(DCC_ADDR_MODE1, 8'(j));
            chk({4'h0, response_mode_sel}, {4'h0, j[1:0], j[1:0]});
        end
        wr(DCC_ADDR_CTRL0, 8'h40);
        rd(DCC_ADDR_CTRL0, 8'h00);
        wr(DCC_ADDR_MUX0, 8'h5a);
        wr(DCC_ADDR_MUX1, 8'hc3);
        chk(pos_input_sel, 8'h3a);
        chk(neg_input_sel, 8'hc5);
        wr(8'ha0, 8'hff);
        rd(8'ha0, 8'h00);
        wr(DCC_ADDR_CTRL0, 8'h8f, 8'h01);
        rd(DCC_ADDR_CTRL0, 8'h00, 8'h01);
        rd(DCC_ADDR_CTRL0, 8'h00);
        $display("register test done");
        edges(0);
        edges(1);
        complete_run();
    end
endmodule : dual_comparator_control_tb_top
